/* File: see_map.svh */
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH

// ----------------------------------------------------------------------------
// Select word layout
// ----------------------------------------------------------------------------
`define SEE_TYPE_CODE    4'hA
`define SEE_TYPE_MSB     7
`define SEE_TYPE_LSB     4
`define SEE_SEL_MSB      3
`define SEE_SEL_LSB      1
`define SEE_RW_BIT       0

// ----------------------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------------------
`define SEE_BYTE_BITS    8
`define SEE_ADDR_W       13
`define SEE_PAGE_BITS    5
`define SEE_STRAP_W      3
`define SEE_FIFO_DEPTH   4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SEE_PROG_TIME_MS 5
`define SEE_MCLK_KHZ     250000
`define SEE_PROG_CYCLES  (`SEE_PROG_TIME_MS * `SEE_MCLK_KHZ)
`define SEE_MAX_SCL_KHZ  400
`endif

/* File: see_pkg.sv */
`include "see_map.svh"
package see_pkg;
  // Bus engine states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK  = 3'h2,
    ST_SEND = 3'h3,
    ST_RACK = 3'h4,
    ST_WAIT = 3'h5
  } see_state_t;

  // Which byte of a transaction is being received.
  typedef enum logic [1:0] {
    PH_SEL  = 2'h0,
    PH_AHI  = 2'h1,
    PH_ALO  = 2'h2,
    PH_DATA = 2'h3
  } see_phase_t;

  // One write byte on its way to the page buffer.
  typedef struct packed {
    logic [`SEE_PAGE_BITS-1:0] offset;
    logic [`SEE_BYTE_BITS-1:0] data;
  } see_wr_t;

  // Pins that come from outside the clock domain.
  typedef struct packed {
    logic                    scl;
    logic                    sda;
    logic                    wp;
    logic [`SEE_STRAP_W-1:0] strap;
  } see_pins_t;
endpackage

/* File: see_sync.sv */
`timescale 1ns/1ns
module see_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] dout_q;
  logic [W-1:0] agree;

  // A bit is taken over once the second and third stages agree.
  assign agree = ~(s2_q ^ s3_q);
  assign dout  = dout_q;

  // Three-stage chain; the first stage feeds only the second.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q   <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
      dout_q <= RST_VAL;
    end else if (clkEn) begin
      s1_q   <= din;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      dout_q <= (dout_q & ~agree) | (s3_q & agree);
    end
  end
endmodule

/* File: see_fifo.sv */
`timescale 1ns/1ns
module see_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         clkEn,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("see_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wrPtr_q;
  logic [AW:0]  rdPtr_q;
  logic         push;
  logic         pop;

  // Full when pointers differ only in the wrap bit.
  assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem[rdPtr_q[AW-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and storage update.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else if (clkEn) begin
      if (push) begin
        mem[wrPtr_q[AW-1:0]] <= inData;
        wrPtr_q              <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && !inReady) |=> (wrPtr_q == $past(wrPtr_q)) || $past(pop))
    else $error("fifo accepted a word while full");
endmodule

/* File: see_target.sv */
`timescale 1ns/1ns
`include "see_map.svh"
module see_target #(
  parameter int PROG_CYCLES = `SEE_PROG_CYCLES,
  parameter int FIFO_DEPTH  = `SEE_FIFO_DEPTH
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    clkEn,
  input  wire logic                    sclIn,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe_n,
  input  wire logic [`SEE_STRAP_W-1:0] strapSel,
  input  wire logic                    wpIn,
  output logic                         progBusy
);
  localparam int PAGE = 1 << `SEE_PAGE_BITS;
  localparam int CW   = $clog2(PROG_CYCLES + 1);
  localparam int BASE = `SEE_ADDR_W - `SEE_PAGE_BITS;
  localparam int HI_W = `SEE_ADDR_W - `SEE_BYTE_BITS;

  if (PROG_CYCLES <= PAGE) begin : g_bad_prog
    $error("PROG_CYCLES must exceed the page size");
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // --------------------------------------------------------------------------
  see_pkg::see_pins_t pinsRaw;
  see_pkg::see_pins_t pins;
  logic               sclPrev_q;
  logic               sdaPrev_q;
  logic               sclRise;
  logic               sclFall;
  logic               startDet;
  logic               stopDet;

  assign pinsRaw = '{scl: sclIn, sda: sdaIn, wp: wpIn, strap: strapSel};

  see_sync #(
    .W       ($bits(see_pkg::see_pins_t)),
    .RST_VAL ({1'b1, 1'b1, 1'b1, {`SEE_STRAP_W{1'b0}}})
  ) u_sync (
    .mclk  (mclk),
    .rst   (rst),
    .clkEn (clkEn),
    .din   (pinsRaw),
    .dout  (pins)
  );

  // Edges of the filtered clock and data levels.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclPrev_q <= pins.scl;
      sdaPrev_q <= pins.sda;
    end
  end

  // Data moves with the clock high only for start and stop.
  assign sclRise  = pins.scl && !sclPrev_q;
  assign sclFall  = !pins.scl && sclPrev_q;
  assign startDet = pins.scl && sclPrev_q && sdaPrev_q && !pins.sda;
  assign stopDet  = pins.scl && sclPrev_q && !sdaPrev_q && pins.sda;

  // --------------------------------------------------------------------------
  // State and decisions
  // --------------------------------------------------------------------------
  see_pkg::see_state_t        state_q;
  see_pkg::see_phase_t        phase_q;
  logic [2:0]                 bitCnt_q;
  logic                       rxFull_q;
  logic                       rdNext_q;
  logic                       ackGiven_q;
  logic                       isRead_q;
  logic                       wrData_q;
  logic [`SEE_BYTE_BITS-1:0]  shift_q;
  logic [`SEE_BYTE_BITS-1:0]  txByte_q;
  logic [`SEE_ADDR_W-1:0]     addr_q;
  logic                       sdaOe_n_q;
  logic                       sdaOut_q;
  logic                       progPend_q;
  logic                       progAct_q;
  logic                       progBusy_q;
  logic [CW-1:0]              progCnt_q;
  logic [BASE-1:0]            pageBase_q;
  logic [PAGE-1:0]            pageMask_q;
  logic [`SEE_BYTE_BITS-1:0]  pageBuf [PAGE];
  logic [`SEE_BYTE_BITS-1:0]  mem [1 << `SEE_ADDR_W];

  logic                       busy;
  logic                       selMatch;
  logic                       ackData;
  logic                       ackNow;
  logic                       rxBit;
  logic                       rxEnd;
  logic                       ackEdge;
  logic                       enterSend;
  logic                       pushWr;
  logic                       fifoInReady;
  logic                       fifoOutValid;
  logic                       progStart;
  logic                       progDone;
  logic                       progCopy;
  logic [`SEE_PAGE_BITS-1:0]  progIdx;
  logic [`SEE_BYTE_BITS-1:0]  memByte;
  see_pkg::see_wr_t           wrIn;
  see_pkg::see_wr_t           wrOut;

  assign busy = progPend_q || progAct_q;

  // Select word check; an open strap pin is pulled low at the pad.
  assign selMatch =
    (shift_q[`SEE_TYPE_MSB:`SEE_TYPE_LSB] == `SEE_TYPE_CODE) &&
    (shift_q[`SEE_SEL_MSB:`SEE_SEL_LSB] == pins.strap);

  // Data is refused under protection or when the buffer is full.
  assign ackData = !pins.wp && fifoInReady;

  // Answer chosen at the falling edge that follows the eighth bit.
  assign ackNow = (phase_q == see_pkg::PH_SEL)  ? selMatch && !busy :
                  (phase_q == see_pkg::PH_DATA) ? ackData : 1'b1;

  assign rxBit   = state_q == see_pkg::ST_RECV && sclRise && !rxFull_q;
  assign rxEnd   = state_q == see_pkg::ST_RECV && sclFall && rxFull_q;
  assign ackEdge = state_q == see_pkg::ST_ACK && sclFall;
  assign enterSend =
    (ackEdge && ackGiven_q && phase_q == see_pkg::PH_SEL && isRead_q) ||
    (state_q == see_pkg::ST_RACK && sclFall && rdNext_q);
  assign pushWr  = rxEnd && phase_q == see_pkg::PH_DATA && ackData;
  assign memByte = mem[addr_q];
  assign wrIn    = '{offset: addr_q[`SEE_PAGE_BITS-1:0], data: shift_q};

  // --------------------------------------------------------------------------
  // Bus engine
  // --------------------------------------------------------------------------
  // Start and stop override every state; else one step per clock edge.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q  <= see_pkg::ST_IDLE;
      bitCnt_q <= 3'h0;
      rxFull_q <= 1'b0;
      rdNext_q <= 1'b0;
    end else if (clkEn) begin
      if (startDet) begin
        state_q  <= see_pkg::ST_RECV;
        bitCnt_q <= 3'h0;
        rxFull_q <= 1'b0;
      end else if (stopDet) begin
        state_q <= see_pkg::ST_IDLE;
      end else if (rxBit) begin
        bitCnt_q <= bitCnt_q + 3'h1;
        rxFull_q <= bitCnt_q == 3'h7;
      end else if (rxEnd) begin
        state_q <= see_pkg::ST_ACK;
      end else if (enterSend) begin
        state_q  <= see_pkg::ST_SEND;
        bitCnt_q <= 3'h0;
        rdNext_q <= 1'b0;
      end else if (ackEdge) begin
        state_q  <= ackGiven_q ? see_pkg::ST_RECV : see_pkg::ST_WAIT;
        bitCnt_q <= 3'h0;
        rxFull_q <= 1'b0;
      end else if (state_q == see_pkg::ST_SEND && sclFall) begin
        bitCnt_q <= bitCnt_q + 3'h1;
        if (bitCnt_q == 3'h7) begin
          state_q <= see_pkg::ST_RACK;
        end
      end else if (state_q == see_pkg::ST_RACK && sclRise) begin
        rdNext_q <= !pins.sda;
      end else if (state_q == see_pkg::ST_RACK && sclFall) begin
        state_q <= see_pkg::ST_WAIT;
      end
    end
  end

  // Open-drain driver: only the enable moves, after a falling edge, a start or a stop.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sdaOe_n_q <= 1'b1;
      sdaOut_q  <= 1'b0;
    end else if (clkEn) begin
      sdaOut_q <= 1'b0;
      if (startDet || stopDet) begin
        sdaOe_n_q <= 1'b1;
      end else if (rxEnd) begin
        sdaOe_n_q <= !ackNow;
      end else if (enterSend) begin
        sdaOe_n_q <= memByte[`SEE_BYTE_BITS-1];
      end else if (ackEdge) begin
        sdaOe_n_q <= 1'b1;
      end else if (state_q == see_pkg::ST_SEND && sclFall) begin
        sdaOe_n_q <= (bitCnt_q == 3'h7) || txByte_q[`SEE_BYTE_BITS-2];
      end
    end
  end

  // Byte shifters, select bookkeeping and address register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_q    <= see_pkg::PH_SEL;
      shift_q    <= '0;
      txByte_q   <= '0;
      addr_q     <= '0;
      ackGiven_q <= 1'b0;
      isRead_q   <= 1'b0;
      wrData_q   <= 1'b0;
    end else if (clkEn) begin
      if (startDet) begin
        phase_q  <= see_pkg::PH_SEL;
        wrData_q <= 1'b0;
      end else if (stopDet) begin
        wrData_q <= 1'b0;
      end else if (rxBit) begin
        shift_q <= {shift_q[`SEE_BYTE_BITS-2:0], pins.sda};
      end else if (rxEnd) begin
        ackGiven_q <= ackNow;
        unique case (phase_q)
          see_pkg::PH_SEL: begin
            isRead_q <= shift_q[`SEE_RW_BIT];
          end
          see_pkg::PH_AHI: begin
            addr_q[`SEE_ADDR_W-1:`SEE_BYTE_BITS] <= shift_q[HI_W-1:0];
          end
          see_pkg::PH_ALO: begin
            addr_q[`SEE_BYTE_BITS-1:0] <= shift_q;
          end
          see_pkg::PH_DATA: begin
            wrData_q <= ackData;
            if (ackData) begin
              addr_q[`SEE_PAGE_BITS-1:0] <=
                addr_q[`SEE_PAGE_BITS-1:0] + 1'b1;
            end
          end
        endcase
      end else if (enterSend) begin
        txByte_q <= memByte;
      end else if (ackEdge && phase_q != see_pkg::PH_DATA) begin
        phase_q <= see_pkg::see_phase_t'(phase_q + 2'h1);
      end else if (state_q == see_pkg::ST_SEND && sclFall) begin
        txByte_q <= {txByte_q[`SEE_BYTE_BITS-2:0], 1'b0};
      end else if (state_q == see_pkg::ST_RACK && sclRise && !pins.sda) begin
        addr_q <= addr_q + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Write buffer and programming cycle
  // --------------------------------------------------------------------------
  see_fifo #(
    .W     ($bits(see_pkg::see_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .rst      (rst),
    .clkEn    (clkEn),
    .inValid  (pushWr),
    .inReady  (fifoInReady),
    .inData   (wrIn),
    .outValid (fifoOutValid),
    .outReady (!progAct_q),
    .outData  (wrOut)
  );

  // Programming waits until the buffer has drained into the page.
  assign progStart = progPend_q && !fifoOutValid && !progAct_q;
  assign progDone  = progAct_q && progCnt_q == CW'(PROG_CYCLES - 1);
  assign progCopy  = progAct_q && progCnt_q < CW'(PAGE);
  assign progIdx   = progCnt_q[`SEE_PAGE_BITS-1:0];

  // Pending, active and cycle count of the internal write.
  always_ff @(posedge mclk) begin
    if (rst) begin
      progPend_q <= 1'b0;
      progAct_q  <= 1'b0;
      progCnt_q  <= '0;
      progBusy_q <= 1'b0;
      pageBase_q <= '0;
    end else if (clkEn) begin
      progBusy_q <= busy || (stopDet && wrData_q && !isRead_q);
      if (stopDet && wrData_q && !isRead_q && !busy) begin
        progPend_q <= 1'b1;
        pageBase_q <= addr_q[`SEE_ADDR_W-1:`SEE_PAGE_BITS];
      end else if (progStart) begin
        progPend_q <= 1'b0;
        progAct_q  <= 1'b1;
        progCnt_q  <= '0;
      end else if (progDone) begin
        progAct_q <= 1'b0;
      end else if (progAct_q) begin
        progCnt_q <= progCnt_q + 1'b1;
      end
    end
  end

  // Page buffer: later bytes at one offset overwrite earlier ones.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pageMask_q <= '0;
    end else if (clkEn) begin
      if (progDone || (startDet && !busy)) begin
        pageMask_q <= '0;
      end else if (fifoOutValid && !progAct_q) begin
        pageBuf[wrOut.offset]    <= wrOut.data;
        pageMask_q[wrOut.offset] <= 1'b1;
      end
    end
  end

  // Array update, one page byte per clock at the start of the cycle.
  always_ff @(posedge mclk) begin
    if (clkEn && progCopy && pageMask_q[progIdx]) begin
      mem[{pageBase_q, progIdx}] <= pageBuf[progIdx];
    end
  end

  assign sdaOut   = sdaOut_q;
  assign sdaOe_n  = sdaOe_n_q;
  assign progBusy = progBusy_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || !clkEn);

  drive_low_only_a: assert property (sdaOut_q == 1'b0)
    else $error("data line driven high");

  change_on_fall_a: assert property (
    $changed(sdaOe_n_q) |-> $past(sclFall) || $past(startDet) ||
                            $past(stopDet))
    else $error("data enable moved outside a falling edge");

  sel_mismatch_nack_a: assert property (
    rxEnd && phase_q == see_pkg::PH_SEL && !selMatch
      |=> sdaOe_n_q ##0 !ackGiven_q)
    else $error("foreign select word acknowledged");

  busy_sel_nack_a: assert property (
    rxEnd && phase_q == see_pkg::PH_SEL && busy |=> sdaOe_n_q)
    else $error("select acknowledged while programming");

  protect_nack_a: assert property (
    rxEnd && phase_q == see_pkg::PH_DATA && pins.wp
      |=> sdaOe_n_q && !wrData_q)
    else $error("protected data byte acknowledged");

  page_wrap_a: assert property (
    pushWr |=> addr_q == {$past(addr_q[`SEE_ADDR_W-1:`SEE_PAGE_BITS]),
                          $past(addr_q[`SEE_PAGE_BITS-1:0]) + 5'h01})
    else $error("page write moved upper address bits");

  stop_launch_a: assert property (
    stopDet && wrData_q && !isRead_q && !busy |=> progPend_q ##1 progBusy_q)
    else $error("stop after write data did not launch programming");

  prog_length_a: assert property (
    $fell(progAct_q) |-> $past(progCnt_q) == CW'(PROG_CYCLES - 1))
    else $error("programming cycle length wrong");

  wait_released_a: assert property (
    state_q == see_pkg::ST_WAIT |-> sdaOe_n_q)
    else $error("line held after refused read");

  read_release_a: assert property (
    state_q == see_pkg::ST_SEND && sclFall && bitCnt_q == 3'h7
      |=> sdaOe_n_q && state_q == see_pkg::ST_RACK)
    else $error("line not released for read acknowledge");
endmodule

/* File: see_bus_ctl.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Two-wire bus controller model
// ----------------------------------------------------------------------------
module see_bus_ctl (
  input  wire logic mclk,
  input  wire logic sdaWire,
  output logic      sclOut,
  output logic      sdaRel
);
  localparam int Q = 10;
  int lowWait = Q;

  // The clock idles high and the data line is released between frames.
  initial begin
    sclOut = 1'b1;
    sdaRel = 1'b1;
  end

  // Waits a number of system clock edges.
  task automatic wq(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Data falls while the clock is high, then the clock goes low.
  task automatic start();
    sdaRel <= 1'b1;
    wq(Q);
    sclOut <= 1'b1;
    wq(Q);
    sdaRel <= 1'b0;
    wq(Q);
    sclOut <= 1'b0;
  endtask

  // Data rises while the clock is high and the bus is left idle.
  task automatic stop();
    wq(Q);
    sdaRel <= 1'b0;
    wq(Q);
    sclOut <= 1'b1;
    wq(Q);
    sdaRel <= 1'b1;
    wq(Q);
  endtask

  // One clock of 160 ns; lowWait stretches the low phase for a slow host.
  task automatic bitx(input logic b, output logic s);
    wq(lowWait);
    sdaRel <= b;
    wq(Q);
    sclOut <= 1'b1;
    wq(Q);
    s = sdaWire;
    wq(Q);
    sclOut <= 1'b0;
  endtask

  // Sends a byte MSB first and samples the answer on the ninth clock.
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, ack);
  endtask

  // Takes a byte with the line released, then answers with ack.
  task automatic recvByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(ack, s);
  endtask
endmodule

/* File: serial_eeprom_bus_target_test.sv */
`timescale 1ns/1ns
`include "see_map.svh"
module serial_eeprom_bus_target_test;
  logic                    mclk     = 1'b0;
  logic                    rst      = 1'b1;
  logic                    wpIn     = 1'b0;
  logic                    clkEn    = 1'b1;
  logic [`SEE_STRAP_W-1:0] strapSel = 3'h5;
  logic                    sclOut;
  logic                    sdaRel;
  logic                    sdaOut;
  logic                    sdaOe_n;
  logic                    progBusy;
  logic                    sdaWire;
  int                      n_mismatch  = 0;
  int                      check_count = 0;

  // ---------------------------------------------------------------------------
  // Clock, wire and instances
  // ---------------------------------------------------------------------------
  always #2 mclk = ~mclk;
  // The pulled-up line is low when either party pulls it.
  assign sdaWire = sdaRel & (sdaOe_n | sdaOut);

  see_target #(.PROG_CYCLES(2000), .FIFO_DEPTH(4)) dut_u (
    .mclk(mclk), .rst(rst), .clkEn(clkEn), .sclIn(sclOut), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .strapSel(strapSel), .wpIn(wpIn),
    .progBusy(progBusy));
  see_bus_ctl ctl_u (.mclk(mclk), .sdaWire(sdaWire), .sclOut(sclOut),
    .sdaRel(sdaRel));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Compares a value and counts the check.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Waits a bounded time for programming to end.
  task automatic waitIdle();
    int i;
    for (i = 0; i < 2100 && progBusy !== 1'b0; i++) @(posedge mclk);
    if (i == 2100) begin
      chk({7'h0, progBusy}, 8'h0);
      final_report();
    end
  endtask

  // Start, write select and two address bytes; upper bits are junk.
  task automatic wrHead(input logic [12:0] a);
    logic k;
    ctl_u.start();
    ctl_u.sendByte(8'hAA, k);
    chk({7'h0, k}, 8'h0);
    ctl_u.sendByte({3'h7, a[12:8]}, k);
    chk({7'h0, k}, 8'h0);
    ctl_u.sendByte(a[7:0], k);
    chk({7'h0, k}, 8'h0);
  endtask

  // Random read of n bytes, most significant expected byte first.
  task automatic rdChk(input logic [12:0] a, input logic [15:0] e,
                       input int n);
    logic k;
    logic [7:0] d;
    logic [15:0] t;
    wrHead(a);
    ctl_u.start();
    ctl_u.sendByte(8'hAB, k);
    chk({7'h0, k}, 8'h0);
    for (int i = 0; i < n; i++) begin
      ctl_u.recvByte(i == n - 1, d);
      t = e >> (8 * (n - 1 - i));
      chk(d, t[7:0]);
    end
    ctl_u.stop();
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Every strap code and one bad type code; then all straps open.
  task automatic s_select();
    logic k;
    for (int s = 0; s < 9; s++) begin
      ctl_u.start();
      ctl_u.sendByte((s == 8) ? 8'hBA : {4'hA, 3'(s), 1'b0}, k);
      ctl_u.stop();
      chk({7'h0, k}, {7'h0, s != 5});
    end
    strapSel <= 3'h0;
    ctl_u.start();
    ctl_u.sendByte(8'hA0, k);
    ctl_u.stop();
    chk({7'h0, k}, 8'h0);
    strapSel <= 3'h5;
  endtask

  // Byte write, polling while busy, then read back.
  task automatic s_byte();
    logic k;
    wrHead(13'h1234);
    ctl_u.sendByte(8'h5C, k);
    chk({7'h0, k}, 8'h0);
    ctl_u.stop();
    chk({7'h0, progBusy}, 8'h1);
    // A frozen clock enable must hold the programming count.
    clkEn <= 1'b0;
    repeat (2500) @(posedge mclk);
    chk({7'h0, progBusy}, 8'h1);
    clkEn <= 1'b1;
    ctl_u.start();
    ctl_u.sendByte(8'hAA, k);
    ctl_u.stop();
    chk({7'h0, k}, 8'h1);
    ctl_u.start();
    ctl_u.sendByte(8'hAB, k);
    ctl_u.stop();
    chk({7'h0, k}, 8'h1);
    waitIdle();
    rdChk(13'h1234, 16'h005C, 1);
  endtask

  // Slow host writes 34 bytes from offset 30 so the page wraps.
  task automatic s_page();
    logic k;
    ctl_u.lowWait = 30;
    wrHead(13'h0A3E);
    for (int i = 0; i < 34; i++) begin
      ctl_u.sendByte(8'h40 + 8'(i), k);
      chk({7'h0, k}, 8'h0);
    end
    ctl_u.stop();
    ctl_u.lowWait = 10;
    waitIdle();
    rdChk(13'h0A3E, 16'h6061, 2);
    rdChk(13'h0A20, 16'h4243, 2);
  endtask

  // Protected byte and page write are refused; reads still work.
  task automatic s_protect();
    logic k;
    wpIn <= 1'b1;
    wrHead(13'h1234);
    ctl_u.sendByte(8'hE7, k);
    chk({7'h0, k}, 8'h1);
    ctl_u.sendByte(8'hE8, k);
    chk({7'h0, k}, 8'h1);
    ctl_u.stop();
    chk({7'h0, progBusy}, 8'h0);
    rdChk(13'h1234, 16'h005C, 1);
    wpIn <= 1'b0;
  endtask

  // After a refused read byte with no stop the line stays released.
  task automatic s_nack();
    logic k;
    logic [7:0] d;
    wrHead(13'h0A3F);
    ctl_u.start();
    ctl_u.sendByte(8'hAB, k);
    ctl_u.recvByte(1'b1, d);
    chk(d, 8'h61);
    ctl_u.recvByte(1'b1, d);
    chk(d, 8'hFF);
    ctl_u.stop();
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    s_select();
    s_byte();
    s_page();
    s_protect();
    s_nack();
    final_report();
  end
endmodule
